// file: verilog/usr_shift_top.sv
// eight-stage universal shift and storage register with axi4-lite status port
//
// Contract
// RQ1: selects pick hold, right, left, load
// RQ2: eight stages share eight two-way port pins
// RQ3: load captures port pin levels each edge; with capture on, a full fifo freezes the stages and skips the capture
// RQ4: load mode forces port drivers off
// RQ5: partner holds port pins steady during load
// RQ6: low clear zeroes all stages, overrides mode; with capture on, a full fifo freezes the stages and holds the clear off
// RQ7: either enable high floats ports, logic continues
// RQ8: enables low, not loading: drive stages
// RQ9: right shift: serial into first, move up
// RQ10: left shift: serial into last, move down
// RQ11: hold mode or no edge keeps stages
// RQ12: serial end outputs always driven
// RQ13: chained devices share clock and selects
// RQ14: stages change only on rising edge
`timescale 1ns/10ps
module usr_shift_top
  import usr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // mode and clear pins
  input wire logic mode_select_low_i,
  input wire logic mode_select_high_i,
  input wire logic sync_zero_n_i,
  // port drive enable pins
  input wire logic port_drive_enable_a_n_i,
  input wire logic port_drive_enable_b_n_i,
  // serial pins
  input wire logic left_serial_in_i,
  input wire logic right_serial_in_i,
  output logic first_stage_serial_out_o,
  output logic last_stage_serial_out_o,
  // two-way port pins, bit 0 is port_bit_first, bit 7 is port_bit_last
  input wire logic [STAGES-1:0] port_bits_i,
  output logic [STAGES-1:0] port_bits_o,
  output logic port_bits_oe_n_o,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic usr_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    return (addr == CTRL_OFFS) ? SEL_CTRL : (addr == STATUS_OFFS) ? SEL_STATUS
      : (addr == DATA_OFFS) ? SEL_DATA : SEL_NONE;
  endfunction

  function automatic usr_mode_t mode_decode(input logic sel_high, input logic sel_low);
    // enum order matches the select code: hold, right, left, load
    return usr_mode_t'({sel_high, sel_low});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and agreement filter

  usr_pins_t pins_raw;
  usr_pins_t pins_s1_reg;
  usr_pins_t pins_s2_reg;
  usr_pins_t pins_s3_reg;
  usr_pins_t pins_reg;
  logic [$bits(usr_pins_t)-1:0] agree;

  assign pins_raw = '{
    mode_select_high: mode_select_high_i,
    mode_select_low: mode_select_low_i,
    sync_zero_n: sync_zero_n_i,
    port_drive_enable_a_n: port_drive_enable_a_n_i,
    port_drive_enable_b_n: port_drive_enable_b_n_i,
    left_serial_in: left_serial_in_i,
    right_serial_in: right_serial_in_i,
    port_bits: port_bits_i
  };

  // first stage is read by the second only
  assign agree = ~(pins_s2_reg ^ pins_s3_reg);

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      pins_s1_reg <= PINS_RESET;
      pins_s2_reg <= PINS_RESET;
      pins_s3_reg <= PINS_RESET;
      pins_reg <= PINS_RESET;
    end
    else
    begin
      pins_s1_reg <= pins_raw;
      pins_s2_reg <= pins_s1_reg;
      pins_s3_reg <= pins_s2_reg;
      // a bit changes only once two samples agree, so glitches die here
      pins_reg <= (pins_reg & ~agree) | (pins_s3_reg & agree);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stage logic

  usr_mode_t mode;
  logic [STAGES-1:0] stage_reg;
  logic [STAGES-1:0] stage_next;
  logic stage_update;
  logic stage_step;
  logic capture_reg;
  logic push_ready;
  logic port_float;

  assign mode = mode_decode(pins_reg.mode_select_high, pins_reg.mode_select_low); // [RQ1]

  always_comb
  begin
    stage_next = stage_reg;
    if (!pins_reg.sync_zero_n)
    begin
      stage_next = '0; // [RQ6]
    end
    else
    begin
      unique case (mode)
        MODE_HOLD: stage_next = stage_reg; // [RQ11]
        MODE_RIGHT: stage_next = {stage_reg[STAGES-2:0], pins_reg.right_serial_in}; // [RQ9]
        MODE_LEFT: stage_next = {pins_reg.left_serial_in, stage_reg[STAGES-1:1]}; // [RQ10]
        MODE_LOAD: stage_next = pins_reg.port_bits; // [RQ3] [RQ5]
      endcase
    end
  end

  assign stage_update = !pins_reg.sync_zero_n || mode != MODE_HOLD;
  // with capture on, a full fifo freezes the stages rather than lose a snapshot
  assign stage_step = !(capture_reg && stage_update && !push_ready);

  // rising edge only; srst is a system reset, not the device clear
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      stage_reg <= STAGE_RESET;
    end
    else if (stage_step)
    begin
      stage_reg <= stage_next; // [RQ14] [RQ2]
    end
  end

  assign first_stage_serial_out_o = stage_reg[0]; // [RQ12] [RQ13]
  assign last_stage_serial_out_o = stage_reg[STAGES-1]; // [RQ12] [RQ13]

  assign port_float = mode == MODE_LOAD // [RQ4]
    || pins_reg.port_drive_enable_a_n || pins_reg.port_drive_enable_b_n; // [RQ7]
  assign port_bits_oe_n_o = port_float; // [RQ8]
  assign port_bits_o = stage_reg; // [RQ8]

  ////////////////////////////////////////////////////////////////////////////////
  // snapshot fifo

  logic [STAGES-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  usr_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .in_valid_i(capture_reg && stage_update),
    .in_ready_o(push_ready),
    .in_data_i(stage_next),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data),
    .level_o(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;

  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb0_reg <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_decode(aw_addr_reg) == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_reg && s_axi_bready_i)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      capture_reg <= CTRL_CAPTURE_RESET;
    end
    else if (wr_fire && w_strb0_reg && reg_decode(aw_addr_reg) == SEL_CTRL)
    begin
      capture_reg <= w_data_reg[CTRL_CAPTURE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_take;
  usr_sel_t rd_sel;
  logic [31:0] status_word;

  assign s_axi_arready_o = !rvalid_reg;
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_sel = reg_decode(s_axi_araddr_i);
  // a data read pops one snapshot; reading empty returns valid low
  assign fifo_pop = rd_take && rd_sel == SEL_DATA;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  always_comb
  begin
    status_word = '0;
    status_word[STAT_STAGE_LSB +: STAGES] = stage_reg;
    status_word[STAT_MODE_LSB +: 2] = mode;
    status_word[STAT_DRIVE_BIT] = !port_float;
    status_word[STAT_STALL_BIT] = !stage_step;
    status_word[STAT_LEVEL_LSB +: $clog2(FIFO_DEPTH)+1] = fifo_level;
    status_word[STAT_EMPTY_BIT] = !fifo_valid;
    status_word[STAT_FULL_BIT] = !push_ready;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      unique case (rd_sel)
        SEL_CTRL: rdata_reg[CTRL_CAPTURE_BIT] <= capture_reg;
        SEL_STATUS: rdata_reg <= status_word;
        SEL_DATA: rdata_reg <= {23'h0, fifo_valid, fifo_data};
        SEL_NONE: rresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_mode_hold_keep: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ11] [RQ1]
    (pins_reg.sync_zero_n && !pins_reg.mode_select_high && !pins_reg.mode_select_low)
    |=> $stable(stage_reg))
    else $error("stages moved in hold mode");
  a_load_capture: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ3]
    (pins_reg.sync_zero_n && mode == MODE_LOAD && stage_step)
    |=> stage_reg == $past(pins_reg.port_bits))
    else $error("load did not capture port levels");
  a_load_float: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ4]
    (pins_reg.mode_select_high && pins_reg.mode_select_low) |-> port_bits_oe_n_o)
    else $error("port driven during load");
  a_clear_zeroes: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ6]
    (!pins_reg.sync_zero_n && stage_step)
    |=> stage_reg == '0 && !first_stage_serial_out_o && !last_stage_serial_out_o)
    else $error("clear left a stage high");
  a_enable_float: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ7]
    (pins_reg.port_drive_enable_a_n || pins_reg.port_drive_enable_b_n) |-> port_bits_oe_n_o)
    else $error("port driven while disabled");
  a_port_drive: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ8]
    (!pins_reg.port_drive_enable_a_n && !pins_reg.port_drive_enable_b_n && mode != MODE_LOAD)
    |-> !port_bits_oe_n_o && port_bits_o == stage_reg)
    else $error("port not driving stages");
  a_shift_right: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ9]
    (pins_reg.sync_zero_n && mode == MODE_RIGHT && stage_step)
    |=> stage_reg == {$past(stage_reg[STAGES-2:0]), $past(pins_reg.right_serial_in)})
    else $error("right shift wrong");
  a_shift_left: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ10]
    (pins_reg.sync_zero_n && mode == MODE_LEFT && stage_step)
    |=> stage_reg == {$past(pins_reg.left_serial_in), $past(stage_reg[STAGES-1:1])})
    else $error("left shift wrong");
  a_serial_ends: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ12]
    stage_step |=> first_stage_serial_out_o == $past(stage_next[0])
    && last_stage_serial_out_o == $past(stage_next[STAGES-1]))
    else $error("serial ends not following stages");
  a_stall_freeze: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RQ14]
    !stage_step |=> $stable(stage_reg))
    else $error("stages moved while stalled");

endmodule // usr_shift_top

// file: verilog/usr_pkg.sv
// shared constants, modes and bundles of the universal shift storage register
package usr_pkg;

  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 12'h004;
  localparam logic [ADDR_W-1:0] DATA_OFFS = 12'h008;

  // control fields and reset values
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam logic CTRL_CAPTURE_RESET = 1'h0;

  // status fields
  localparam int STAT_STAGE_LSB = 0;
  localparam int STAT_MODE_LSB = 8;
  localparam int STAT_DRIVE_BIT = 10;
  localparam int STAT_STALL_BIT = 11;
  localparam int STAT_LEVEL_LSB = 16;
  localparam int STAT_EMPTY_BIT = 24;
  localparam int STAT_FULL_BIT = 25;

  // data word fields
  localparam int DATA_VALID_BIT = 8;

  localparam logic [STAGES-1:0] STAGE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_HOLD, MODE_RIGHT, MODE_LEFT, MODE_LOAD} usr_mode_t;

  // register index after address decode
  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_DATA, SEL_NONE} usr_sel_t;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic sync_zero_n;
    logic port_drive_enable_a_n;
    logic port_drive_enable_b_n;
    logic left_serial_in;
    logic right_serial_in;
    logic [STAGES-1:0] port_bits;
  } usr_pins_t;

  // idle pin levels: clear and enables inactive
  localparam usr_pins_t PINS_RESET = 15'h1c00;

endpackage

// file: verilog/usr_fifo.sv
// synchronous valid/ready fifo holding stage snapshots
`timescale 1ns/10ps
module usr_fifo
  import usr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // fill level
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem[rd_ptr_reg];
  assign level_o = count_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  ////////////////////////////////////////////////////////////////////////////////
  // storage has no reset; only pointers and count need one
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      // depth is a power of two, pointers wrap naturally
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // usr_fifo

// file: bench/usr_bus_partner.sv
// parallel bus neighbour sharing the two-way port pins with the device
`timescale 1ns/10ps
module usr_bus_partner
  import usr_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // neighbour side
  input wire logic drive_i,
  input wire logic [STAGES-1:0] value_i,
  // device side
  input wire logic [STAGES-1:0] dev_bits_i,
  input wire logic dev_oe_n_i,
  // resolved pin levels
  output logic [STAGES-1:0] bus_o
);
  logic [STAGES-1:0] last_reg = 8'h00;
  //////////////////////////////////////////////////////////////////////////////
  // no pull on the pins: a released bus toggles, so a stale value never passes
  always @(posedge sys_clk_i)
  begin
    last_reg <= bus_o;
  end
  // neighbour keeps its value steady for the whole load window
  assign bus_o = !dev_oe_n_i ? dev_bits_i : drive_i ? value_i : ~last_reg;
endmodule // usr_bus_partner

// file: bench/universal_shift_storage_reg8_test.sv
// self-checking bench for the shift storage register and its status port
`timescale 1ns/10ps
module universal_shift_storage_reg8_test
  import usr_pkg::*;
  ();
  typedef struct {
    usr_mode_t mode;
    logic zero_n;
    logic ena_n;
    logic enb_n;
    logic lsi;
    logic rsi;
    logic [STAGES-1:0] bus;
    int cyc;
    logic [STAGES-1:0] st;
    logic oe_n;
  } usr_row_t;
  // rows chain: each starts from the stages the row before left
  usr_row_t rows [7] = '{
    '{MODE_LOAD, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'ha5, 6, 8'ha5, 1'b1},
    '{MODE_RIGHT, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 6, 8'h7f, 1'b0},
    '{MODE_LEFT, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 6, 8'h01, 1'b1},
    '{MODE_HOLD, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 6, 8'h01, 1'b1},
    '{MODE_LEFT, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 6, 8'hfc, 1'b0},
    '{MODE_RIGHT, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 6, 8'h3f, 1'b0},
    '{MODE_LOAD, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h5a, 6, 8'h00, 1'b1}
  };
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic msl = 1'b0;
  logic msh = 1'b0;
  logic zero_n = 1'b1;
  logic ena_n = 1'b0;
  logic enb_n = 1'b0;
  logic lsi = 1'b0;
  logic rsi = 1'b0;
  logic first_o;
  logic last_o;
  logic [STAGES-1:0] port_in;
  logic [STAGES-1:0] port_o;
  logic oe_n;
  logic part_drv = 1'b0;
  logic [STAGES-1:0] part_val = 8'h00;
  logic [ADDR_W-1:0] awaddr = 12'h000;
  logic [ADDR_W-1:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int miscompares = 0;
  int comparisons = 0;
  //////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;

  usr_bus_partner partner (.sys_clk_i(sys_clk), .drive_i(part_drv), .value_i(part_val),
    .dev_bits_i(port_o), .dev_oe_n_i(oe_n), .bus_o(port_in));

  usr_shift_top uut (.sys_clk_i(sys_clk), .srst_i(srst), .mode_select_low_i(msl),
    .mode_select_high_i(msh), .sync_zero_n_i(zero_n), .port_drive_enable_a_n_i(ena_n),
    .port_drive_enable_b_n_i(enb_n), .left_serial_in_i(lsi), .right_serial_in_i(rsi),
    .first_stage_serial_out_o(first_o), .last_stage_serial_out_o(last_o),
    .port_bits_i(port_in), .port_bits_o(port_o), .port_bits_oe_n_o(oe_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_pin(input string n, input logic [STAGES-1:0] e, input logic [STAGES-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic set_pins(input usr_mode_t m, input logic c, a, b, l, r);
    msl <= m[0];
    msh <= m[1];
    zero_n <= c;
    ena_n <= a;
    enb_n <= b;
    lsi <= l;
    rsi <= r;
  endtask

  // waits on the slave's answer with no cycle count; only the watchdog ends a hang
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  initial
  begin
    logic [31:0] rd;
    logic [1:0] resp;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    axi_rd(CTRL_OFFS, rd, resp);
    chk_reg("ctrl reset", {31'h0, CTRL_CAPTURE_RESET}, rd);
    axi_rd(STATUS_OFFS, rd, resp);
    chk_reg("status reset", 32'h0100_0000, rd & 32'h0300_00ff);
    // filtered pins: hold n cycles gives exactly n acting edges
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      set_pins(rows[i].mode, rows[i].zero_n, rows[i].ena_n, rows[i].enb_n, rows[i].lsi,
        rows[i].rsi);
      part_drv <= (rows[i].mode == MODE_LOAD);
      part_val <= rows[i].bus;
      repeat (rows[i].cyc) @(posedge sys_clk);
      chk_pin("pins floated", {7'h0, rows[i].oe_n}, {7'h0, oe_n});
      set_pins(MODE_HOLD, 1'b1, 1'b0, 1'b0, rows[i].lsi, rows[i].rsi);
      repeat (8) @(posedge sys_clk);
      chk_pin("stages", rows[i].st, port_o);
      chk_pin("port pins", rows[i].st, port_in);
      chk_pin("serial ends", {6'h0, rows[i].st[7], rows[i].st[0]}, {6'h0, last_o, first_o});
      part_drv <= 1'b0;
    end
    axi_rd(12'h00c, rd, resp);
    chk_reg("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], resp});
    axi_wr(12'h010, 32'h1, resp);
    chk_reg("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_wr(STATUS_OFFS, 32'hffff_ffff, resp);
    chk_reg("ro write", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_wr(CTRL_OFFS, 32'h1, resp);
    axi_rd(CTRL_OFFS, rd, resp);
    chk_reg("ctrl capture", 32'h1, rd);
    // byte lane 0 off: the capture bit must not move
    wstrb <= 4'h0;
    axi_wr(CTRL_OFFS, 32'h0, resp);
    wstrb <= 4'hf;
    axi_rd(CTRL_OFFS, rd, resp);
    chk_reg("ctrl strobe", 32'h1, rd);
    // overfill: a full fifo must freeze the stages, not drop snapshots
    @(posedge sys_clk);
    set_pins(MODE_RIGHT, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (24) @(posedge sys_clk);
    set_pins(MODE_HOLD, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge sys_clk);
    axi_rd(STATUS_OFFS, rd, resp);
    chk_reg("status full", 32'h0210_04ff, rd & 32'h031f_0fff);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      axi_rd(DATA_OFFS, rd, resp);
      chk_reg("snapshot", {23'h0, 1'b1, (i < 8) ? 8'hff >> (7 - i) : 8'hff}, rd);
    end
    axi_rd(DATA_OFFS, rd, resp);
    chk_reg("empty pop", 32'h0, {23'h0, rd[8], 8'h00});
    axi_rd(STATUS_OFFS, rd, resp);
    chk_reg("status empty", 32'h0100_0000, rd & 32'h0300_0000);
    // second reset in mid-run with nonzero stages
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_pin("reset stages", STAGE_RESET, port_o);
    chk_pin("reset float", 8'h01, {7'h0, oe_n});
    srst <= 1'b0;
    axi_rd(CTRL_OFFS, rd, resp);
    chk_reg("ctrl after reset", 32'h0, rd);
    close_out();
  end
endmodule // universal_shift_storage_reg8_test
